// File: pkg/ssp_pkg.sv
// package: register map, field positions, reset values and states of the pin state block
package ssp_pkg;

  // default number of port pins handled by one instance
  localparam int unsigned NPIN = 8;
  // avalon byte address width
  localparam int unsigned AW = 6;
  // register data width
  localparam int unsigned DW = 32;

  // register byte offsets
  localparam logic [5:0] ADDR_CTRL = 6'h00; // control bits
  localparam logic [5:0] ADDR_DOUT = 6'h04; // port output data
  localparam logic [5:0] ADDR_DIR = 6'h08; // port direction, 1 = output
  localparam logic [5:0] ADDR_PULLUP = 6'h0c; // pull-up enables
  localparam logic [5:0] ADDR_FSEL = 6'h10; // 1 = peripheral function
  localparam logic [5:0] ADDR_CMPO = 6'h14; // 1 = comparator output pin
  localparam logic [5:0] ADDR_EXTEN = 6'h18; // external interrupt enables
  localparam logic [5:0] ADDR_PININ = 6'h1c; // gated pin input, read only
  localparam logic [5:0] ADDR_MODE = 6'h20; // mode status, read only
  localparam logic [5:0] ADDR_IRQ_ST = 6'h24; // sticky events, write one to clear
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h28; // event mask

  // standby_control_register fields
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CTRL_SPL = 0; // pin_state_select
  localparam int unsigned CTRL_I2CW = 1; // two-wire bus wake-up enable
  localparam int unsigned CTRL_CMPIE = 2; // comparator interrupt enable
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // mode status fields
  localparam int unsigned MODE_W = 4;
  localparam int unsigned MODE_RUN = 0;
  localparam int unsigned MODE_STBY = 1;
  localparam int unsigned MODE_FLOAT = 2;
  localparam int unsigned MODE_SLEEP = 3;

  // event bits of status and mask registers
  localparam int unsigned NEV = 4;
  localparam int unsigned EV_EXT = 0; // external interrupt edge
  localparam int unsigned EV_CMP = 1; // comparator interrupt edge
  localparam int unsigned EV_I2C = 2; // bus wake-up in standby
  localparam int unsigned EV_EXIT = 3; // standby left
  localparam logic [NEV-1:0] MASK_RST = 4'h0;

  // pin group mode
  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_RUN = 3'b010,
    ST_STBY = 3'b100
  } ssp_state_t;

endpackage : ssp_pkg

// File: rtl/ssp_pin_cell.sv
// one port pin: next output value, output enable, gated input and interrupt path
module ssp_pin_cell (
  input wire logic init_i, // reset state, pins floated
  input wire logic stby_i, // stop or watch mode
  input wire logic spl_i, // pin_state_select
  input wire logic dout_i, // port data register bit
  input wire logic dir_i, // port direction bit
  input wire logic fsel_i, // peripheral function select
  input wire logic cmpo_i, // comparator output pin select
  input wire logic periph_out_i, // peripheral output value
  input wire logic periph_oe_i, // peripheral output enable
  input wire logic cmp_out_i, // comparator output value
  input wire logic hold_o_i, // output captured at standby entry
  input wire logic hold_oe_i, // enable captured at standby entry
  input wire logic pad_in_i, // pin level
  input wire logic exten_i, // external interrupt enable
  output logic nxt_o_o, // next pin output value
  output logic nxt_oe_o, // next pin output enable
  output logic gate_o, // next gated input
  output logic ext_o // next external interrupt level
);

  // output selection per mode
  always_comb
  begin
    nxt_o_o = 1'b0;
    nxt_oe_o = 1'b0;
    if (init_i)
    begin
      nxt_o_o = 1'b0;
      nxt_oe_o = 1'b0;
    end
    else if (cmpo_i)
    begin
      nxt_o_o = cmp_out_i;
      nxt_oe_o = 1'b1;
    end
    else if (stby_i)
    begin
      nxt_o_o = hold_o_i;
      nxt_oe_o = spl_i ? 1'b0 : hold_oe_i;
    end
    else if (fsel_i)
    begin
      nxt_o_o = periph_out_i;
      nxt_oe_o = periph_oe_i;
    end
    else
    begin
      nxt_o_o = dout_i;
      nxt_oe_o = dir_i;
    end
  end

  assign gate_o = pad_in_i & ~init_i & ~stby_i;
  assign ext_o = pad_in_i & exten_i;

endmodule : ssp_pin_cell

// File: rtl/ssp_irq.sv
// sticky event status with write-one-to-clear, mask and one level interrupt
module ssp_irq #(
  parameter int unsigned NEV = ssp_pkg::NEV
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable, freezes state when low
  input wire logic [NEV-1:0] ev_i, // event inputs: one-cycle pulses, the bus wake-up bit a level
  input wire logic clr_we_i, // write to status register
  input wire logic mask_we_i, // write to mask register
  input wire logic [NEV-1:0] wdata_i, // write data
  output logic [NEV-1:0] status_o, // sticky status bits
  output logic [NEV-1:0] mask_o, // mask bits
  output logic irq_o // level interrupt
);

  // all state of this module
  typedef struct packed {
    logic [NEV-1:0] status;
    logic [NEV-1:0] mask;
  } ssp_irq_t;

  ssp_irq_t q; // registered state
  ssp_irq_t d; // next state

  // set wins over a clear in the same cycle
  always_comb
  begin
    d = q;
    d.status = (q.status & ~(clr_we_i ? wdata_i : '0)) | ev_i;
    if (mask_we_i)
    begin
      d.mask = wdata_i;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      q.status <= '0;
      q.mask <= ssp_pkg::MASK_RST;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  assign status_o = q.status;
  assign mask_o = q.mask;
  assign irq_o = |(q.status & q.mask);

endmodule : ssp_irq

// File: rtl/ssp_pin_state.sv
// pin state control of lcd common and segment port pins across run, sleep, stop and watch
module ssp_pin_state #(
  parameter int unsigned N = ssp_pkg::NPIN // pins, at most eight
) (
  input wire logic clk_sys_i, // system clock, 125 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic ce_i, // clock enable
  input wire logic stop_i, // stop mode active
  input wire logic watch_i, // watch mode active
  input wire logic sleep_i, // sleep mode active, pins unaffected
  input wire logic i2c_wake_i, // bus interface wake request
  input wire logic cmp_result_i, // comparator analogue result
  input wire logic cmp_out_i, // comparator output value
  input wire logic [N-1:0] periph_out_i, // peripheral output values
  input wire logic [N-1:0] periph_oe_i, // peripheral output enables
  input wire logic [N-1:0] pad_in_i, // pin levels
  output logic [N-1:0] pad_out_o, // pin output values
  output logic [N-1:0] pad_oe_o, // pin output enables, high drives
  output logic [N-1:0] pad_pu_o, // pin pull-up enables
  output logic [N-1:0] pin_in_o, // gated pin inputs to peripherals
  output logic [N-1:0] extint_o, // external interrupt levels
  output logic cmp_irq_o, // comparator interrupt level
  output logic wake_o, // wake request to clock control
  output logic irq_o, // block interrupt level
  input wire logic [ssp_pkg::AW-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [ssp_pkg::DW-1:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte enables
  output logic [ssp_pkg::DW-1:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o // stall until answer ready
);

  // all state of the block except the sticky status and mask kept in u_irq
  typedef struct packed {
    ssp_pkg::ssp_state_t st; // pin group mode
    logic [ssp_pkg::CTRL_W-1:0] ctrl; // standby_control_register
    logic [N-1:0] dout; // port data
    logic [N-1:0] dir; // port direction
    logic [N-1:0] pu; // pull-up enables
    logic [N-1:0] fsel; // peripheral select
    logic [N-1:0] cmpo; // comparator output pins
    logic [N-1:0] exten; // external interrupt enables
    logic [N-1:0] hold_o; // outputs kept in standby
    logic [N-1:0] hold_oe; // enables kept in standby
    logic [N-1:0] pad_o; // registered pin outputs
    logic [N-1:0] pad_oe; // registered pin enables
    logic [N-1:0] pin_in; // registered gated inputs
    logic [N-1:0] ext; // registered interrupt levels
    logic cmp_irq; // registered comparator interrupt
    logic wake; // registered wake request
    logic ack; // bus answer cycle
    logic [ssp_pkg::DW-1:0] rdata; // read data
  } ssp_core_t;

  ssp_core_t q; // registered state
  ssp_core_t d; // next state

  logic [N-1:0] nxt_o; // per-pin next output
  logic [N-1:0] nxt_oe; // per-pin next enable
  logic [N-1:0] gate; // per-pin gated input
  logic [N-1:0] ext_w; // per-pin interrupt level
  logic [ssp_pkg::NEV-1:0] ev; // event pulses
  logic [ssp_pkg::NEV-1:0] irq_st; // sticky status
  logic [ssp_pkg::NEV-1:0] irq_mask; // mask
  logic req; // bus request present
  logic wr; // write takes effect
  logic stby_req; // stop or watch asked for
  logic in_stby; // group in standby
  logic clr_we; // status clear strobe
  logic mask_we; // mask write strobe

  assign req = avs_read_i | avs_write_i;
  assign wr = avs_write_i & q.ack & avs_byteenable_i[0];
  assign stby_req = stop_i | watch_i;
  assign in_stby = (q.st == ssp_pkg::ST_STBY);
  assign clr_we = wr & (avs_address_i == ssp_pkg::ADDR_IRQ_ST);
  assign mask_we = wr & (avs_address_i == ssp_pkg::ADDR_IRQ_MASK);

  // one cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_pin
      ssp_pin_cell u_cell (
        .init_i (q.st == ssp_pkg::ST_INIT),
        .stby_i (in_stby),
        .spl_i (q.ctrl[ssp_pkg::CTRL_SPL]),
        .dout_i (q.dout[gi]),
        .dir_i (q.dir[gi]),
        .fsel_i (q.fsel[gi]),
        .cmpo_i (q.cmpo[gi]),
        .periph_out_i (periph_out_i[gi]),
        .periph_oe_i (periph_oe_i[gi]),
        .cmp_out_i (cmp_out_i),
        .hold_o_i (q.hold_o[gi]),
        .hold_oe_i (q.hold_oe[gi]),
        .pad_in_i (pad_in_i[gi]),
        .exten_i (q.exten[gi]),
        .nxt_o_o (nxt_o[gi]),
        .nxt_oe_o (nxt_oe[gi]),
        .gate_o (gate[gi]),
        .ext_o (ext_w[gi])
      );
    end
  endgenerate

  // event pulses for the status register
  always_comb
  begin
    ev = '0;
    ev[ssp_pkg::EV_EXT] = |(ext_w & ~q.ext);
    ev[ssp_pkg::EV_CMP] = d.cmp_irq & ~q.cmp_irq;
    ev[ssp_pkg::EV_I2C] = in_stby & i2c_wake_i & q.ctrl[ssp_pkg::CTRL_I2CW];
    ev[ssp_pkg::EV_EXIT] = in_stby & ~stby_req;
  end

  // sticky status and mask
  ssp_irq #(
    .NEV (ssp_pkg::NEV)
  ) u_irq (
    .clk_sys_i (clk_sys_i),
    .rst_i (rst_i),
    .ce_i (ce_i),
    .ev_i (ev),
    .clr_we_i (clr_we),
    .mask_we_i (mask_we),
    .wdata_i (avs_writedata_i[ssp_pkg::NEV-1:0]),
    .status_o (irq_st),
    .mask_o (irq_mask),
    .irq_o (irq_o)
  );

  // next state of the block, apart from the sticky status and mask in u_irq
  always_comb
  begin
    d = q;
    // bus answer one cycle after the request
    d.ack = req & ~q.ack;
    if (req & ~q.ack)
    begin
      d.rdata = '0;
      case (avs_address_i)
        ssp_pkg::ADDR_CTRL: d.rdata[ssp_pkg::CTRL_W-1:0] = q.ctrl;
        ssp_pkg::ADDR_DOUT: d.rdata[N-1:0] = q.dout;
        ssp_pkg::ADDR_DIR: d.rdata[N-1:0] = q.dir;
        ssp_pkg::ADDR_PULLUP: d.rdata[N-1:0] = q.pu;
        ssp_pkg::ADDR_FSEL: d.rdata[N-1:0] = q.fsel;
        ssp_pkg::ADDR_CMPO: d.rdata[N-1:0] = q.cmpo;
        ssp_pkg::ADDR_EXTEN: d.rdata[N-1:0] = q.exten;
        ssp_pkg::ADDR_PININ: d.rdata[N-1:0] = q.pin_in;
        ssp_pkg::ADDR_MODE:
        begin
          d.rdata[ssp_pkg::MODE_RUN] = (q.st == ssp_pkg::ST_RUN);
          d.rdata[ssp_pkg::MODE_STBY] = in_stby;
          d.rdata[ssp_pkg::MODE_FLOAT] = in_stby & q.ctrl[ssp_pkg::CTRL_SPL];
          d.rdata[ssp_pkg::MODE_SLEEP] = sleep_i;
        end
        ssp_pkg::ADDR_IRQ_ST: d.rdata[ssp_pkg::NEV-1:0] = irq_st;
        ssp_pkg::ADDR_IRQ_MASK: d.rdata[ssp_pkg::NEV-1:0] = irq_mask;
        // unmapped reads as zero
        default: d.rdata = '0;
      endcase
    end
    // register writes on the answer cycle
    if (wr)
    begin
      case (avs_address_i)
        ssp_pkg::ADDR_CTRL: d.ctrl = avs_writedata_i[ssp_pkg::CTRL_W-1:0];
        ssp_pkg::ADDR_DOUT: d.dout = avs_writedata_i[N-1:0];
        ssp_pkg::ADDR_DIR: d.dir = avs_writedata_i[N-1:0];
        ssp_pkg::ADDR_PULLUP: d.pu = avs_writedata_i[N-1:0];
        ssp_pkg::ADDR_FSEL: d.fsel = avs_writedata_i[N-1:0];
        ssp_pkg::ADDR_CMPO: d.cmpo = avs_writedata_i[N-1:0];
        ssp_pkg::ADDR_EXTEN: d.exten = avs_writedata_i[N-1:0];
        // read-only, irq or unmapped: ignored here
        default: d.dout = q.dout;
      endcase
    end
    // pin group mode
    case (q.st)
      ssp_pkg::ST_INIT:
      begin
        d.st = ssp_pkg::ST_RUN;
      end
      ssp_pkg::ST_RUN:
      begin
        // sleep alone leaves pins in run
        if (stby_req)
        begin
          d.st = ssp_pkg::ST_STBY;
          d.hold_o = q.pad_o;
          d.hold_oe = q.pad_oe;
        end
      end
      ssp_pkg::ST_STBY:
      begin
        if (~stby_req)
        begin
          d.st = ssp_pkg::ST_RUN;
        end
      end
      default:
      begin
        d.st = ssp_pkg::ST_INIT;
      end
    endcase
    // pin outputs and gated inputs
    d.pad_o = nxt_o;
    d.pad_oe = nxt_oe;
    d.pin_in = gate;
    d.ext = ext_w;
    d.cmp_irq = cmp_result_i & q.ctrl[ssp_pkg::CTRL_CMPIE];
    d.wake = in_stby & ((|ext_w) | d.cmp_irq
             | (i2c_wake_i & q.ctrl[ssp_pkg::CTRL_I2CW]));
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= ssp_pkg::ST_INIT;
      q.ctrl <= ssp_pkg::CTRL_RST;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  // outputs
  assign pad_out_o = q.pad_o;
  assign pad_oe_o = q.pad_oe;
  assign pad_pu_o = q.pu;
  assign pin_in_o = q.pin_in;
  assign extint_o = q.ext;
  assign cmp_irq_o = q.cmp_irq;
  assign wake_o = q.wake;
  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = req & ~q.ack;

  // checks on the pin state behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  property p_run_normal;
    (q.st == ssp_pkg::ST_RUN) && ce_i && !stby_req |=>
      (pad_oe_o & ~$past(q.cmpo)) == ((($past(q.fsel) & $past(periph_oe_i))
      | (~$past(q.fsel) & $past(q.dir))) & ~$past(q.cmpo));
  endproperty
  a_run_normal: assert property (p_run_normal)
    else $error("run mode pin enable wrong");

  property p_hold;
    in_stby && ce_i && !q.ctrl[ssp_pkg::CTRL_SPL] |=>
      ((pad_oe_o ^ $past(q.hold_oe)) & ~$past(q.cmpo)) == '0;
  endproperty
  a_hold: assert property (p_hold)
    else $error("standby pin did not keep state");

  property p_float;
    in_stby && ce_i && q.ctrl[ssp_pkg::CTRL_SPL] |=> pad_oe_o == $past(q.cmpo);
  endproperty
  a_float: assert property (p_float)
    else $error("standby pin not floated");

  property p_gate;
    (q.st != ssp_pkg::ST_RUN) && ce_i |=> pin_in_o == '0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("input gate open in standby or reset");

  property p_reset_float;
    $past(rst_i) |-> pad_oe_o == '0 && pin_in_o == '0;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("pins not floated after reset");

  property p_ext;
    ce_i |=> extint_o == ($past(pad_in_i) & $past(q.exten));
  endproperty
  a_ext: assert property (p_ext)
    else $error("external interrupt blocked");

  property p_cmp_out;
    in_stby && ce_i |=> ((pad_out_o ^ {N{$past(cmp_out_i)}}) & $past(q.cmpo)) == '0
      && (pad_oe_o & $past(q.cmpo)) == $past(q.cmpo);
  endproperty
  a_cmp_out: assert property (p_cmp_out)
    else $error("comparator output lost in standby");

  property p_cmp_irq;
    ce_i |=> cmp_irq_o == ($past(cmp_result_i) && $past(q.ctrl[ssp_pkg::CTRL_CMPIE]));
  endproperty
  a_cmp_irq: assert property (p_cmp_irq)
    else $error("comparator interrupt wrong");

  property p_wake;
    in_stby && ce_i && i2c_wake_i && q.ctrl[ssp_pkg::CTRL_I2CW] |=> wake_o;
  endproperty
  a_wake: assert property (p_wake)
    else $error("bus wake-up missed");

  property p_exit;
    in_stby && ce_i && !stby_req |=> q.st == ssp_pkg::ST_RUN;
  endproperty
  a_exit: assert property (p_exit)
    else $error("standby not left");

  // gate open again whenever the group runs, one edge behind the pin
  property p_gate_open;
    (q.st == ssp_pkg::ST_RUN) && ce_i |=> pin_in_o == $past(pad_in_i);
  endproperty
  a_gate_open: assert property (p_gate_open)
    else $error("input gate not reopened");

  cover_float: cover property (in_stby && q.ctrl[ssp_pkg::CTRL_SPL]);
  cover_hold: cover property (in_stby && !q.ctrl[ssp_pkg::CTRL_SPL] ##1 !in_stby);
  cover_wake: cover property (wake_o && irq_o);
  cover_exit: cover property (in_stby && !stby_req ##1 q.st == ssp_pkg::ST_RUN);

endmodule : ssp_pin_state

// File: test/ssp_pad_model.sv
// partner model: external circuitry that resolves each pin level from all drivers
module ssp_pad_model #(
  parameter int unsigned N = 8 // pins
) (
  input wire logic clk_sys_i, // system clock
  input wire logic [N-1:0] pad_out_i, // device output values
  input wire logic [N-1:0] pad_oe_i, // device output enables
  input wire logic [N-1:0] pad_pu_i, // device pull-up enables
  input wire logic [N-1:0] ext_en_i, // external driver enables
  input wire logic [N-1:0] ext_val_i, // external driver values
  output logic [N-1:0] pad_in_o // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // undriven pins wander: a changing pattern so a stale value never passes
  logic [N-1:0] float_q = '0;

  // toggle the floating pattern every cycle
  always_ff @(posedge clk_sys_i)
  begin
    float_q <= ~float_q;
  end

  // pin level: device driver, then external driver, then pull-up, else floating
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (pad_oe_i[i])
        pad_in_o[i] = pad_out_i[i]; // device drives
      else if (ext_en_i[i])
        pad_in_o[i] = ext_val_i[i]; // board drives a defined level
      else if (pad_pu_i[i])
        pad_in_o[i] = 1'b1; // pull-up holds high
      else
        pad_in_o[i] = float_q[i]; // nothing holds the pin
    end
  end
endmodule : ssp_pad_model

// File: test/tb.sv
// testbench: bus tasks and mode sequences for the pin state block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned N = 8; // pins under test
  // registers read back as zero after reset, last one unmapped
  localparam logic [5:0] RA [9] = '{ssp_pkg::ADDR_CTRL, ssp_pkg::ADDR_DOUT, ssp_pkg::ADDR_DIR,
    ssp_pkg::ADDR_PULLUP, ssp_pkg::ADDR_FSEL, ssp_pkg::ADDR_CMPO, ssp_pkg::ADDR_EXTEN,
    ssp_pkg::ADDR_IRQ_MASK, 6'h3c};
  logic clk = 1'b0; // system clock
  logic rst = 1'b1; // synchronous reset
  logic ce = 1'b1; // clock enable
  logic stop = 1'b0; // stop mode request
  logic watch = 1'b0; // watch mode request
  logic sleep = 1'b0; // sleep mode
  logic wake_req = 1'b0; // bus wake request
  logic cmp_res = 1'b0; // comparator result
  logic cmp_out = 1'b0; // comparator output value
  logic [N-1:0] p_out = '0; // peripheral outputs
  logic [N-1:0] p_oe = '0; // peripheral enables
  logic [N-1:0] ext_en = '0; // board driver enables
  logic [N-1:0] ext_val = '0; // board driver values
  logic [5:0] adr = '0; // bus address
  logic rd = 1'b0; // bus read
  logic wr = 1'b0; // bus write
  logic [31:0] wdat = '0; // bus write data
  logic [N-1:0] pad_out, pad_oe, pad_pu, pin_in, extint, pad_in; // pin side
  logic cmp_irq, wake, irq, wait_r; // single outputs
  logic [31:0] rdat; // bus read data
  logic [31:0] q; // last read value
  int failures = 0;
  int comparisons = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  // device under test
  ssp_pin_state #(.N(N)) dut (
    .clk_sys_i(clk), .rst_i(rst), .ce_i(ce), .stop_i(stop), .watch_i(watch),
    .sleep_i(sleep), .i2c_wake_i(wake_req), .cmp_result_i(cmp_res), .cmp_out_i(cmp_out),
    .periph_out_i(p_out), .periph_oe_i(p_oe), .pad_in_i(pad_in), .pad_out_o(pad_out),
    .pad_oe_o(pad_oe), .pad_pu_o(pad_pu), .pin_in_o(pin_in), .extint_o(extint),
    .cmp_irq_o(cmp_irq), .wake_o(wake), .irq_o(irq), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r));

  // board around the pins
  ssp_pad_model #(.N(N)) pads (
    .clk_sys_i(clk), .pad_out_i(pad_out), .pad_oe_i(pad_oe), .pad_pu_i(pad_pu),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_in_o(pad_in));

  // verdict and end of run
  task final_report();
    if (failures == 0 && comparisons > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  // one avalon transfer, held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wait_r !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
    begin
      failures++;
      $display("[FAIL] %0t bus timeout", $time);
      final_report();
    end
    else
    begin
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask : bus

  // register write
  task wr_reg(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr_reg

  // register read and compare
  task rd_chk(input logic [5:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(q, exp, what);
  endtask : rd_chk

  // let n edges pass, then sample settled outputs
  task look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : look

  // bound on the whole run
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("[FAIL] %0t run timeout", $time);
    final_report();
  end

  // main sequence
  initial
  begin
    look(1);
    chk(pad_oe, 32'h0, "reset float");
    chk(pin_in, 32'h0, "reset gate");
    @(posedge clk);
    rst <= 1'b0;
    foreach (RA[i]) rd_chk(RA[i], 32'h0, "reset value");
    wr_reg(ssp_pkg::ADDR_PULLUP, 32'h0f);
    wr_reg(ssp_pkg::ADDR_DIR, 32'hf0);
    wr_reg(ssp_pkg::ADDR_DOUT, 32'ha5);
    wr_reg(ssp_pkg::ADDR_IRQ_MASK, 32'h8);
    @(posedge clk);
    ext_en <= 8'h0f;
    ext_val <= 8'h05;
    look(3);
    chk(pad_oe, 32'hf0, "run enables");
    chk(pin_in, 32'ha5, "run input");
    // clock enable low: a stop request must not be taken
    @(posedge clk);
    ce <= 1'b0;
    stop <= 1'b1;
    look(3);
    chk(pad_oe, 32'hf0, "frozen by clock enable");
    chk(pin_in, 32'ha5, "frozen input gate");
    @(posedge clk);
    ce <= 1'b1;
    stop <= 1'b0;
    @(posedge clk);
    sleep <= 1'b1;
    look(3);
    chk(pad_out & 8'hf0, 32'ha0, "sleep output");
    chk(pin_in, 32'ha5, "sleep input");
    rd_chk(ssp_pkg::ADDR_MODE, 32'h9, "sleep status");
    // stop with outputs held
    @(posedge clk);
    sleep <= 1'b0;
    stop <= 1'b1;
    ext_val <= 8'h0a;
    look(2);
    chk(pad_oe, 32'hf0, "stop hold enable");
    chk(pad_out & 8'hf0, 32'ha0, "stop hold value");
    chk(pin_in, 32'h0, "stop gate");
    rd_chk(ssp_pkg::ADDR_MODE, 32'h2, "stop status");
    @(posedge clk);
    stop <= 1'b0;
    look(3);
    chk(pin_in, 32'haa, "exit input");
    chk(irq, 32'h1, "exit interrupt");
    rd_chk(ssp_pkg::ADDR_IRQ_ST, 32'h8, "exit event");
    wr_reg(ssp_pkg::ADDR_IRQ_ST, 32'h8);
    look(1);
    chk(irq, 32'h0, "interrupt cleared");
    // watch with outputs floated
    wr_reg(ssp_pkg::ADDR_CTRL, 32'h1);
    @(posedge clk);
    watch <= 1'b1;
    look(2);
    chk(pad_oe, 32'h0, "watch float");
    chk(pad_pu, 32'h0f, "pull-up kept");
    chk(pin_in, 32'h0, "watch gate");
    rd_chk(ssp_pkg::ADDR_MODE, 32'h6, "watch status");
    wr_reg(ssp_pkg::ADDR_EXTEN, 32'h1);
    @(posedge clk);
    ext_val <= 8'h0b;
    look(2);
    chk(extint, 32'h1, "ext int passes");
    chk(wake, 32'h1, "ext int wakes");
    wr_reg(ssp_pkg::ADDR_EXTEN, 32'h0);
    wr_reg(ssp_pkg::ADDR_CTRL, 32'h5);
    @(posedge clk);
    cmp_res <= 1'b1;
    look(2);
    chk(cmp_irq, 32'h1, "comparator interrupt");
    @(posedge clk);
    cmp_res <= 1'b0;
    wake_req <= 1'b1;
    look(2);
    chk(wake, 32'h0, "bus wake disabled");
    wr_reg(ssp_pkg::ADDR_CTRL, 32'h3);
    look(2);
    chk(wake, 32'h1, "bus wake enabled");
    rd_chk(ssp_pkg::ADDR_IRQ_ST, 32'h7, "events latched");
    chk(irq, 32'h0, "events masked");
    @(posedge clk);
    watch <= 1'b0;
    wake_req <= 1'b0;
    look(3);
    chk(pad_oe, 32'hf0, "watch exit");
    // comparator output pin in stop
    wr_reg(ssp_pkg::ADDR_CTRL, 32'h0);
    wr_reg(ssp_pkg::ADDR_CMPO, 32'h10);
    @(posedge clk);
    stop <= 1'b1;
    cmp_out <= 1'b1;
    look(3);
    chk(pad_out[4], 32'h1, "comparator high");
    @(posedge clk);
    cmp_out <= 1'b0;
    look(2);
    chk(pad_out[4], 32'h0, "comparator low");
    @(posedge clk);
    stop <= 1'b0;
    // peripheral function pin in run
    wr_reg(ssp_pkg::ADDR_FSEL, 32'h80);
    @(posedge clk);
    p_oe <= 8'h80;
    p_out <= 8'h80;
    look(3);
    chk(pad_out[7], 32'h1, "peripheral drives");
    final_report();
  end
endmodule : tb
